/* include/mdss_defines.vh */
// Constants for the motor driver serial slave port.
// Assumes inclusion by the design files only; definitions only.
`ifndef MDSS_DEFINES_VH
`define MDSS_DEFINES_VH

`define MDSS_FRAME_BITS   40
`define MDSS_DATA_BITS    32
`define MDSS_ADDR_BITS    7
`define MDSS_WSEL_BIT     39
`define MDSS_ADDR_MSB     38
`define MDSS_ADDR_LSB     32
`define MDSS_STAT_MSB     39
`define MDSS_STAT_LSB     32
`define MDSS_ST_STOP_R    7
`define MDSS_ST_STOP_L    6
`define MDSS_ST_POS_RCH   5
`define MDSS_ST_VEL_RCH   4
`define MDSS_ST_STILL     3
`define MDSS_ST_STALL     2
`define MDSS_ST_DRV_ERR   1
`define MDSS_ST_RESET     0
`define MDSS_DRV_STILL_B  31
`define MDSS_DRV_STALL_B  24
`define MDSS_GST_ERR_B    1
`define MDSS_GST_RST_B    0
`define MDSS_CLK_NS       40
`define MDSS_FILT_NS      20
`define MDSS_FILT_CYC     ((`MDSS_FILT_NS + `MDSS_CLK_NS - 1) / `MDSS_CLK_NS)
`define MDSS_REPLY_RST    32'h0000_0000

`endif

/* hdl/mdss_in_filter.v */
// Two-flop synchroniser plus glitch filter for one serial port input.
// Assumes an asynchronous pin level and the system clock mclk.
`timescale 1ns/100ps
`include "mdss_defines.vh"

module mdss_in_filter #(
  parameter FILT_CYC = `MDSS_FILT_CYC,
  parameter RST_VAL  = 1'b1
) (
  // Clock and reset
  input  wire mclk,
  input  wire rst_n,
  // Pin and clean level
  input  wire pin_in,
  output reg  level_r
);

  reg         meta_r;
  reg         sync_r;
  reg         prev_r;
  reg  [3:0]  cnt_r;

  // A new level is taken only after it stays stable for FILT_CYC + 2 cycles.
  always @(posedge mclk) begin
    if (!rst_n) begin
      meta_r  <= RST_VAL;
      sync_r  <= RST_VAL;
      prev_r  <= RST_VAL;
      cnt_r   <= 4'h0;
      level_r <= RST_VAL;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      if (sync_r != prev_r) begin
        cnt_r <= 4'h0;
      end else if (cnt_r < FILT_CYC[3:0]) begin
        cnt_r <= cnt_r + 4'h1;
      end else begin
        level_r <= sync_r;
      end
    end
  end

endmodule // mdss_in_filter

/* hdl/mdss_spi_slave.v */
// Serial slave port of a stepper motor controller, 40-bit datagrams.
// Assumes a mode 3 master, bus clock at most one sixth of mclk, pins async.
`timescale 1ns/100ps
`include "mdss_defines.vh"

module mdss_spi_slave #(
  parameter FRAME_BITS = `MDSS_FRAME_BITS,
  parameter DATA_BITS  = `MDSS_DATA_BITS,
  parameter ADDR_BITS  = `MDSS_ADDR_BITS
) (
  // Clock and reset
  input  wire                 mclk,
  input  wire                 rst_n,
  // Serial pins
  input  wire                 sck,
  input  wire                 sdi,
  input  wire                 csn,
  output reg                  sdo_r,
  output reg                  sdo_oe_r,
  // Register side: commands out
  output reg                  wr_stb_r,
  output reg                  rd_stb_r,
  output reg  [ADDR_BITS-1:0] reg_addr_r,
  output reg  [DATA_BITS-1:0] wr_data_r,
  // Register side: read data for the address on reg_addr_r
  input  wire [DATA_BITS-1:0] rd_data,
  // Status sources from the motion and driver logic
  input  wire                 ramp_stop_r_in,
  input  wire                 ramp_stop_l_in,
  input  wire                 ramp_pos_reached,
  input  wire                 ramp_vel_reached,
  input  wire [DATA_BITS-1:0] drive_state_word,
  input  wire [1:0]           global_state_flags
);

  // Filtered, synchronised pin levels.
  wire sck_f;
  wire sdi_f;
  wire csn_f;

  mdss_in_filter #(.RST_VAL(1'b1)) u_sck (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .pin_in  (sck),
    .level_r (sck_f)
  );

  mdss_in_filter #(.RST_VAL(1'b0)) u_sdi (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .pin_in  (sdi),
    .level_r (sdi_f)
  );

  mdss_in_filter #(.RST_VAL(1'b1)) u_csn (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .pin_in  (csn),
    .level_r (csn_f)
  );

  reg                  sck_d_r;
  reg                  csn_d_r;
  reg [FRAME_BITS-1:0] shift_r;
  reg [7:0]            status_r;
  reg [DATA_BITS-1:0]  reply_r;
  reg                  rd_pend_r;
  reg                  wsel_nxt;

  wire sck_rise = sck_f & ~sck_d_r;
  wire sck_fall = ~sck_f & sck_d_r;
  wire cs_fall  = ~csn_f & csn_d_r;
  wire cs_rise  = csn_f & ~csn_d_r;
  wire active   = ~csn_f;

  // Live status byte, bit order fixed by the reply format.
  wire [7:0] status_live;
  assign status_live[`MDSS_ST_STOP_R]  = ramp_stop_r_in;
  assign status_live[`MDSS_ST_STOP_L]  = ramp_stop_l_in;
  assign status_live[`MDSS_ST_POS_RCH] = ramp_pos_reached;
  assign status_live[`MDSS_ST_VEL_RCH] = ramp_vel_reached;
  assign status_live[`MDSS_ST_STILL] =
    drive_state_word[`MDSS_DRV_STILL_B];
  assign status_live[`MDSS_ST_STALL] =
    drive_state_word[`MDSS_DRV_STALL_B];
  assign status_live[`MDSS_ST_DRV_ERR] =
    global_state_flags[`MDSS_GST_ERR_B];
  assign status_live[`MDSS_ST_RESET] =
    global_state_flags[`MDSS_GST_RST_B];

  always @* begin
    wsel_nxt = shift_r[`MDSS_WSEL_BIT];
  end

  // Edge detection, frame shifting and command latch.
  always @(posedge mclk) begin
    if (!rst_n) begin
      sck_d_r    <= 1'b1;
      csn_d_r    <= 1'b1;
      shift_r    <= {FRAME_BITS{1'b0}};
      status_r   <= 8'h00;
      reply_r    <= `MDSS_REPLY_RST;
      rd_pend_r  <= 1'b0;
      wr_stb_r   <= 1'b0;
      rd_stb_r   <= 1'b0;
      reg_addr_r <= {ADDR_BITS{1'b0}};
      wr_data_r  <= {DATA_BITS{1'b0}};
      sdo_r      <= 1'b0;
      sdo_oe_r   <= 1'b0;
    end else begin
      sck_d_r  <= sck_f;
      csn_d_r  <= csn_f;
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      sdo_oe_r <= active;
      // Read data of the previous read arrives one cycle after rd_stb_r.
      if (rd_pend_r) begin
        reply_r   <= rd_data;
        rd_pend_r <= 1'b0;
      end
      if (cs_fall) begin
        // Load reply: status byte over the address field, data below.
        shift_r <= {status_r, reply_r};
        sdo_r   <= status_r[7];
      end else if (active && sck_rise) begin
        shift_r <= {shift_r[FRAME_BITS-2:0], sdi_f};
      end else if (active && sck_fall) begin
        sdo_r <= shift_r[FRAME_BITS-1];
      end
      if (cs_rise) begin
        // The last 40 bits in the shift register form the command.
        reg_addr_r <= shift_r[`MDSS_ADDR_MSB:`MDSS_ADDR_LSB];
        status_r   <= status_live;
        if (wsel_nxt) begin
          wr_stb_r  <= 1'b1;
          wr_data_r <= shift_r[DATA_BITS-1:0];
          reply_r   <= shift_r[DATA_BITS-1:0];
        end else begin
          rd_stb_r  <= 1'b1;
          rd_pend_r <= 1'b1;
        end
      end
    end
  end

endmodule // mdss_spi_slave

/* dv/mdss_chk.sv */
// Checker on the serial slave port outputs.
// Assumes a bind to mdss_spi_slave; sees its ports only.
`timescale 1ns/100ps
module mdss_chk #(parameter DATA_BITS = 32, parameter ADDR_BITS = 7) (
  // Clock, reset and pins
  input wire mclk, rst_n, csn, sck, sdo_r, sdo_oe_r,
  // Command side
  input wire wr_stb_r, rd_stb_r,
  input wire [ADDR_BITS-1:0] reg_addr_r,
  input wire [DATA_BITS-1:0] wr_data_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_stb_excl: assert property (!(wr_stb_r && rd_stb_r))
    else $error("both strobes");
  a_wr_pulse: assert property (wr_stb_r |=> !wr_stb_r)
    else $error("long write strobe");
  a_rd_pulse: assert property (rd_stb_r |=> !rd_stb_r)
    else $error("long read strobe");
  a_oe_on: assert property (!csn [*7] |-> sdo_oe_r)
    else $error("no drive while selected");
  a_oe_idle: assert property (csn [*8] |-> !sdo_oe_r)
    else $error("drive while idle");
  a_cmd_taken: assert property (!csn [*8] ##1 csn |->
    ##[2:7] (wr_stb_r || rd_stb_r)) else $error("no command");
  a_addr_hold: assert property ($changed(reg_addr_r) |->
    wr_stb_r || rd_stb_r) else $error("address moved");
  a_wdata_hold: assert property ($changed(wr_data_r) |-> wr_stb_r)
    else $error("write data moved");
  a_sdo_still: assert property ((!csn && sck) [*8] |-> $stable(sdo_r))
    else $error("output moved with clock high");
endmodule // mdss_chk

/* dv/mdss_master.sv */
// Bus master model: mode 3 frames of up to 48 bits, first bit highest.
// Assumes mclk at 25 MHz; bus clock half period is 4 mclk.
`timescale 1ns/100ps
module mdss_master (
  input wire mclk, sdo_r, sdo_oe_r,
  output reg sck, sdi, csn
);
  initial begin
    sck = 1'b1;
    sdi = 1'b0;
    csn = 1'b1;
  end
  task automatic wt(input integer c);
    repeat (c) @(posedge mclk);
  endtask
  task automatic xfer(input integer n, input [47:0] tx, output [47:0] rx);
    integer i;
    begin
      rx = 48'h0;
      csn <= 1'b0;
      wt(8);
      for (i = n - 1; i >= 0; i = i - 1) begin
        sck <= 1'b0;
        sdi <= tx[i];
        wt(4);
        sck <= 1'b1;
        wt(4);
        rx[i] = sdo_oe_r ? sdo_r : 1'bx;
      end
      wt(1);
      csn <= 1'b1;
      sdi <= ~sdi;
      wt(12);
    end
  endtask
  // A 10 ns low pulse that straddles one mclk edge.
  task glitch;
    begin
      @(negedge mclk);
      #15 csn = 1'b0;
      #10 csn = 1'b1;
      @(posedge mclk);
    end
  endtask
endmodule // mdss_master

/* dv/testbench.sv */
// Self-checking bench for the serial slave port.
// Assumes the master model and checker are compiled first.
`timescale 1ns/100ps
module testbench;
  reg mclk = 1'b0, rst_n = 1'b0;
  reg ramp_stop_r_in = 0, ramp_stop_l_in = 0;
  reg ramp_pos_reached = 0, ramp_vel_reached = 0;
  reg [31:0] drive_state_word = 32'h0;
  reg [1:0] global_state_flags = 2'h0;
  wire sck, sdi, csn, sdo_r, sdo_oe_r, wr_stb_r, rd_stb_r;
  wire [6:0] reg_addr_r;
  wire [31:0] wr_data_r;
  wire [31:0] rd_data = {reg_addr_r, 25'h1b3c5a1};
  integer n_errors = 0, n_tests = 0, n_stb = 0, n_wr = 0, i, nb;
  reg [47:0] tx [0:7];
  reg [47:0] rx;
  reg [39:0] pc;
  reg [31:0] lw;
  reg [7:0] s, ps;
  always #20 mclk = ~mclk;
  always @(posedge mclk) if (wr_stb_r | rd_stb_r) n_stb = n_stb + 1;
  always @(posedge mclk) if (wr_stb_r) n_wr = n_wr + 1;
  mdss_spi_slave dut (.mclk, .rst_n, .sck, .sdi, .csn, .sdo_r, .sdo_oe_r,
    .wr_stb_r, .rd_stb_r, .reg_addr_r, .wr_data_r, .rd_data,
    .ramp_stop_r_in, .ramp_stop_l_in, .ramp_pos_reached,
    .ramp_vel_reached, .drive_state_word, .global_state_flags);
  mdss_master m (.mclk, .sdo_r, .sdo_oe_r, .sck, .sdi, .csn);
  task check(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    n_errors = n_errors + 1;
    complete_run;
  end
  initial begin
    tx[0] = 48'h21_0000_0000;
    tx[1] = 48'h21_0000_0000;
    tx[2] = 48'ha7_00ab_cdef;
    tx[3] = 48'ha7_0012_3456;
    tx[4] = 48'h05_ffff_ffff;
    tx[5] = 48'h7f_0000_0000;
    tx[6] = 48'hc3_85_0000_0042;
    tx[7] = 48'h00_0000_0000;
    lw = 32'h0;
    s = 8'h3c;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    for (i = 0; i < 8; i = i + 1) begin
      s = s * 8'h1d + 8'h47;
      nb = (i == 6) ? 48 : 40;
      {ramp_stop_r_in, ramp_stop_l_in} <= s[7:6];
      {ramp_pos_reached, ramp_vel_reached} <= s[5:4];
      drive_state_word <= {s[3], 6'h2a, s[2], 24'h5a5a5a};
      global_state_flags <= s[1:0];
      if (i == 4) m.glitch;
      m.xfer(nb, tx[i], rx);
      if (i > 0) begin
        check(rx[nb-1 -: 8], ps);
        check(rx[nb-9 -: 32], pc[39] ? pc[31:0]
          : {pc[38:32], 25'h1b3c5a1});
      end
      if (i == 6) check(rx[7:0], tx[6][47:40]);
      pc = tx[i][39:0];
      if (pc[39]) lw = pc[31:0];
      check(reg_addr_r, pc[38:32]);
      check(wr_data_r, lw);
      ps = s;
      $display("frame %0d done", i);
    end
    check(n_stb, 8);
    check(n_wr, 3);
    complete_run;
  end
endmodule // testbench
bind mdss_spi_slave mdss_chk #(.DATA_BITS(DATA_BITS),
  .ADDR_BITS(ADDR_BITS)) chk (.mclk, .rst_n, .csn, .sck, .sdo_r,
  .sdo_oe_r, .wr_stb_r, .rd_stb_r, .reg_addr_r, .wr_data_r);
